// [rtl/twm_chan.sv]
`timescale 1ns/1ps
`include "twm_map.svh"
module twm_chan (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Timing from the counter.
	input wire logic tick,
	input wire logic match_en,
	input wire logic up,
	input wire logic [15:0] cnt,
	input wire logic [15:0] top,
	input wire logic [15:0] cmp,
	// Configuration.
	input twm_pkg::twm_kind_t kind,
	input wire logic [1:0] action,
	input wire logic tog_ok,
	// Pin override.
	output twm_pkg::twm_pin_t pin
);
	import twm_pkg::*;
	twm_chan_st_t s_ff;
	twm_chan_st_t nxt_s;
	logic match;
	logic bottom;
	logic slope_up;
	logic dual;
	logic oc_en;
	assign match = match_en && (cnt == cmp);
	assign bottom = tick && (cnt == top);
	assign dual = (kind == TWM_K_PC) || (kind == TWM_K_PFC);
	// A match at zero belongs to the rising slope and one at TOP to the falling one.
	assign slope_up = (cnt == `TWM_BOTTOM) || ((cnt != top) && up);
	always_comb begin
		nxt_s = s_ff;
		case (kind)
			TWM_K_NORMAL, TWM_K_CTC: begin
				if (match && action == `TWM_ACT_TGL) begin
					nxt_s.oc = ~s_ff.oc;
				end else if (match && action[1]) begin
					nxt_s.oc = action[0];
				end
			end
			TWM_K_FAST: begin
				if (action[1] && bottom) begin
					nxt_s.oc = ~action[0];
				end else if (action[1] && match && cmp != top) begin
					nxt_s.oc = action[0];
				end else if (action == `TWM_ACT_TGL && tog_ok && match) begin
					nxt_s.oc = ~s_ff.oc;
				end
			end
			TWM_K_PC, TWM_K_PFC: begin
				if (action[1] && match) begin
					nxt_s.oc = slope_up ? action[0] : ~action[0];
				end else if (action == `TWM_ACT_TGL && tog_ok && match) begin
					nxt_s.oc = ~s_ff.oc;
				end
			end
			default: begin
				nxt_s = s_ff;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	// The port direction bit outside still gates the real driver.
	assign oc_en = (action != `TWM_ACT_OFF) && (kind != TWM_K_RSVD) &&
		!(action == `TWM_ACT_TGL && !tog_ok);
	// One assignment drives the whole struct so the port has a single driver.
	assign pin = '{drive: s_ff.oc, enable: oc_en};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_fast_wrap;
		tick && kind == TWM_K_FAST && cnt == top;
	endsequence
	chk_pin_override: assert property (
		(action != `TWM_ACT_OFF && kind == TWM_K_NORMAL) |-> pin.enable)
		else $error("override missing");
	chk_toggle_match: assert property (
		(match && kind == TWM_K_CTC && action == `TWM_ACT_TGL) |=> pin.drive != $past(pin.drive))
		else $error("no toggle on match");
	chk_fast_bottom: assert property (
		(s_fast_wrap and action == `TWM_ACT_CLR) |=> pin.drive)
		else $error("not set at bottom");
	chk_fast_inverted: assert property (
		(s_fast_wrap and action == `TWM_ACT_SET) |=> !pin.drive)
		else $error("not cleared at bottom");
	chk_tgl_disconnect: assert property (
		(kind != TWM_K_NORMAL && kind != TWM_K_CTC && action == `TWM_ACT_TGL && !tog_ok)
		|-> !pin.enable)
		else $error("toggle not disconnected");
	chk_dual_slopes: assert property (
		(match && dual && action[1] && cnt != `TWM_BOTTOM && cnt != top)
		|=> pin.drive == ($past(up) ? $past(action[0]) : ~$past(action[0])))
		else $error("dual slope level wrong");
	chk_reserved_off: assert property (
		kind == TWM_K_RSVD |-> !pin.enable)
		else $error("reserved mode drives pin");
endmodule // twm_chan

// [rtl/twm_map.svh]
// Behaviour
// - Nonzero channel A action field lets compare output A override its pin.
// - Nonzero channel B action field lets compare output B override its pin.
// - Non-PWM modes: action 00 disconnects, action 01 toggles on match.
// - Non-PWM modes: action 10 drives low on match, 11 drives high.
// - Fast PWM action 10: clear on match, set at BOTTOM.
// - Fast PWM action 11: set on match, clear at BOTTOM.
// - Fast PWM action 01: toggle A only in modes 14, 15; B disconnected.
// - Fast PWM actions 10, 11: match at compare equal TOP ignored, BOTTOM action still done.
// - Dual-slope action 01: toggle A only in modes 9, 11; else disconnected.
// - Dual-slope action 10: clear on up-count match, set on down-count match.
// - Dual-slope action 11: set on up-count match, clear on down-count match.
// - Mode is two high bits from control B and two low bits here.
// - Modes 0, 4, 12: TOP max, compare A or capture; immediate load; overflow at MAX.
// - Fast modes: fixed or register TOP; load at BOTTOM; overflow at TOP.
// - Phase correct: fixed or register TOP; load at TOP; overflow at BOTTOM.
// - Modes 8, 9: TOP capture or compare A; load and overflow at BOTTOM.
// - Dual-slope counts from zero up to TOP and back down.
// - Dual-slope counter holds TOP for exactly one timer tick.
// - Dual-slope action 10: compare at BOTTOM gives steady low, at TOP steady high.
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH
`define TWM_OFS_CTRL_A 5'h00
`define TWM_OFS_CTRL_B 5'h04
`define TWM_OFS_PRESC 5'h08
`define TWM_OFS_COUNT 5'h0c
`define TWM_OFS_CMP_A 5'h10
`define TWM_OFS_CMP_B 5'h14
`define TWM_OFS_CAPT 5'h18
`define TWM_OFS_STAT 5'h1c
`define TWM_A_ACT 7:6
`define TWM_B_ACT 5:4
`define TWM_MODE_LO 1:0
`define TWM_MODE_HI 4:3
`define TWM_RUN_BIT 0
`define TWM_ST_OVF 0
`define TWM_ST_UP 1
`define TWM_ST_OCA 2
`define TWM_ST_OCB 3
`define TWM_MAX 16'hffff
`define TWM_BOTTOM 16'h0000
`define TWM_TOP8 16'h00ff
`define TWM_TOP9 16'h01ff
`define TWM_TOP10 16'h03ff
`define TWM_ACT_OFF 2'h0
`define TWM_ACT_TGL 2'h1
`define TWM_ACT_CLR 2'h2
`define TWM_ACT_SET 2'h3
`define TWM_M_NORMAL 4'h0
`define TWM_M_PC8 4'h1
`define TWM_M_PC9 4'h2
`define TWM_M_PC10 4'h3
`define TWM_M_CTC_CMP 4'h4
`define TWM_M_FAST8 4'h5
`define TWM_M_FAST9 4'h6
`define TWM_M_FAST10 4'h7
`define TWM_M_PFC_CAP 4'h8
`define TWM_M_PFC_CMP 4'h9
`define TWM_M_PC_CAP 4'ha
`define TWM_M_PC_CMP 4'hb
`define TWM_M_CTC_CAP 4'hc
`define TWM_M_FAST_CAP 4'he
`define TWM_M_FAST_CMP 4'hf
`endif

// [rtl/twm_pkg.sv]
package twm_pkg;
	typedef enum logic [5:0] {
		TWM_K_NORMAL = 6'h01,
		TWM_K_CTC = 6'h02,
		TWM_K_FAST = 6'h04,
		TWM_K_PC = 6'h08,
		TWM_K_PFC = 6'h10,
		TWM_K_RSVD = 6'h20
	} twm_kind_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} twm_avs_req_t;
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} twm_avs_rsp_t;
	typedef struct packed {
		logic drive;
		logic enable;
	} twm_pin_t;
	typedef struct packed {
		logic oc;
	} twm_chan_st_t;
endpackage

// [rtl/twm_top.sv]
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "twm_map.svh"
module twm_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register bus.
	input twm_pkg::twm_avs_req_t avs_req,
	output twm_pkg::twm_avs_rsp_t avs_rsp,
	// Compare output pin overrides.
	output twm_pkg::twm_pin_t pin_a,
	output twm_pkg::twm_pin_t pin_b
);
	import twm_pkg::*;
	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [1:0] mode_hi;
		logic run;
		logic [7:0] div;
		logic [7:0] pre;
		logic [15:0] cnt;
		logic up;
		logic [15:0] buf_a;
		logic [15:0] buf_b;
		logic [15:0] act_a;
		logic [15:0] act_b;
		logic [15:0] cap;
		logic ovf;
		logic blk;
		logic ack;
		logic [31:0] rdata;
	} twm_state_t;
	twm_state_t s_ff;
	twm_state_t nxt_s;
	twm_kind_t kind;
	logic [3:0] mode;
	logic [15:0] top;
	logic tick;
	logic match_en;
	logic wr_acc;
	logic rd_take;
	logic cnt_wr;
	logic imm;
	logic dual;
	logic ovf_set;
	logic tog_a;
	logic tog_b;
	logic [15:0] cnt_inc;
	logic [15:0] cnt_dec;

	function automatic logic [15:0] twm_merge(
		input logic [15:0] old,
		input logic [15:0] wd,
		input logic [1:0] be
	);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
		return {a[4:2], 2'b00} == ofs;
	endfunction

	assign mode = {s_ff.mode_hi, s_ff.ctrl_a[`TWM_MODE_LO]};
	always_comb begin
		kind = TWM_K_RSVD;
		top = `TWM_MAX;
		case (mode)
			`TWM_M_NORMAL: begin
				kind = TWM_K_NORMAL;
			end
			`TWM_M_CTC_CMP: begin
				kind = TWM_K_CTC;
				top = s_ff.act_a;
			end
			`TWM_M_CTC_CAP: begin
				kind = TWM_K_CTC;
				top = s_ff.cap;
			end
			`TWM_M_PC8, `TWM_M_FAST8: begin
				kind = mode[2] ? TWM_K_FAST : TWM_K_PC;
				top = `TWM_TOP8;
			end
			`TWM_M_PC9, `TWM_M_FAST9: begin
				kind = mode[2] ? TWM_K_FAST : TWM_K_PC;
				top = `TWM_TOP9;
			end
			`TWM_M_PC10, `TWM_M_FAST10: begin
				kind = mode[2] ? TWM_K_FAST : TWM_K_PC;
				top = `TWM_TOP10;
			end
			`TWM_M_PFC_CAP, `TWM_M_PC_CAP, `TWM_M_FAST_CAP: begin
				kind = mode[2] ? TWM_K_FAST : (mode[1] ? TWM_K_PC : TWM_K_PFC);
				top = s_ff.cap;
			end
			`TWM_M_PFC_CMP, `TWM_M_PC_CMP, `TWM_M_FAST_CMP: begin
				kind = mode[2] ? TWM_K_FAST : (mode[1] ? TWM_K_PC : TWM_K_PFC);
				top = s_ff.act_a;
			end
			default: begin
				kind = TWM_K_RSVD;
				top = `TWM_MAX;
			end
		endcase
	end

	assign imm = (kind == TWM_K_NORMAL) || (kind == TWM_K_CTC) || (kind == TWM_K_RSVD);
	assign dual = (kind == TWM_K_PC) || (kind == TWM_K_PFC);
	assign tog_b = (kind == TWM_K_NORMAL) || (kind == TWM_K_CTC);
	assign tog_a = tog_b || (mode == `TWM_M_FAST_CAP) || (mode == `TWM_M_FAST_CMP) ||
		(mode == `TWM_M_PFC_CMP) || (mode == `TWM_M_PC_CMP);
	// The prescaler gives the one-cycle timer tick.
	assign tick = s_ff.run && (s_ff.pre == s_ff.div);
	// A counter write removes the match on the following tick.
	assign match_en = tick && !s_ff.blk;
	assign wr_acc = avs_req.write && s_ff.ack;
	assign rd_take = avs_req.read && !s_ff.ack;
	assign cnt_wr = wr_acc && hit(avs_req.address, `TWM_OFS_COUNT);
	assign cnt_inc = s_ff.cnt + 16'h0001;
	assign cnt_dec = (s_ff.cnt == `TWM_BOTTOM) ? `TWM_BOTTOM : s_ff.cnt - 16'h0001;
	always_comb begin
		ovf_set = 1'b0;
		if (tick && imm && s_ff.cnt == `TWM_MAX) begin
			ovf_set = 1'b1;
		end else if (tick && kind == TWM_K_FAST && s_ff.cnt == top) begin
			ovf_set = 1'b1;
		end else if (tick && dual && !s_ff.up && s_ff.cnt == `TWM_BOTTOM) begin
			ovf_set = 1'b1;
		end
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_s.ack = (avs_req.read || avs_req.write) && !s_ff.ack;
		nxt_s.pre = (!s_ff.run || tick) ? 8'h00 : s_ff.pre + 8'h01;
		if (tick) begin
			nxt_s.blk = 1'b0;
		end
		if (!dual) begin
			nxt_s.up = 1'b1;
		end
		if (tick) begin
			case (kind)
				TWM_K_CTC, TWM_K_FAST: begin
					nxt_s.cnt = (s_ff.cnt == top) ? `TWM_BOTTOM : cnt_inc;
				end
				TWM_K_PC, TWM_K_PFC: begin
					if (s_ff.up && s_ff.cnt >= top) begin
						nxt_s.up = 1'b0;
						nxt_s.cnt = cnt_dec;
					end else if (s_ff.up) begin
						nxt_s.cnt = cnt_inc;
					end else if (s_ff.cnt == `TWM_BOTTOM) begin
						nxt_s.up = 1'b1;
						nxt_s.cnt = (top == `TWM_BOTTOM) ? `TWM_BOTTOM : cnt_inc;
					end else begin
						nxt_s.cnt = cnt_dec;
					end
				end
				default: begin
					nxt_s.cnt = cnt_inc;
				end
			endcase
		end
		if (wr_acc) begin
			if (hit(avs_req.address, `TWM_OFS_CTRL_A)) begin
				if (avs_req.byteenable[0]) begin
					nxt_s.ctrl_a = avs_req.writedata[7:0];
				end
			end else if (hit(avs_req.address, `TWM_OFS_CTRL_B)) begin
				if (avs_req.byteenable[0]) begin
					nxt_s.mode_hi = avs_req.writedata[`TWM_MODE_HI];
					nxt_s.run = avs_req.writedata[`TWM_RUN_BIT];
				end
			end else if (hit(avs_req.address, `TWM_OFS_PRESC)) begin
				if (avs_req.byteenable[0]) begin
					nxt_s.div = avs_req.writedata[7:0];
				end
			end else if (hit(avs_req.address, `TWM_OFS_COUNT)) begin
				nxt_s.cnt = twm_merge(s_ff.cnt, avs_req.writedata[15:0], avs_req.byteenable[1:0]);
				nxt_s.blk = 1'b1;
			end else if (hit(avs_req.address, `TWM_OFS_CMP_A)) begin
				nxt_s.buf_a = twm_merge(s_ff.buf_a, avs_req.writedata[15:0],
					avs_req.byteenable[1:0]);
			end else if (hit(avs_req.address, `TWM_OFS_CMP_B)) begin
				nxt_s.buf_b = twm_merge(s_ff.buf_b, avs_req.writedata[15:0],
					avs_req.byteenable[1:0]);
			end else if (hit(avs_req.address, `TWM_OFS_CAPT)) begin
				nxt_s.cap = twm_merge(s_ff.cap, avs_req.writedata[15:0], avs_req.byteenable[1:0]);
			end else if (hit(avs_req.address, `TWM_OFS_STAT)) begin
				if (avs_req.byteenable[0] && avs_req.writedata[`TWM_ST_OVF]) begin
					nxt_s.ovf = 1'b0;
				end
			end
		end
		// Setting after the clear keeps an overflow that lands on a clear.
		if (ovf_set) begin
			nxt_s.ovf = 1'b1;
		end
		if (imm) begin
			nxt_s.act_a = nxt_s.buf_a;
			nxt_s.act_b = nxt_s.buf_b;
		end else if (tick && kind == TWM_K_FAST && s_ff.cnt == top) begin
			nxt_s.act_a = s_ff.buf_a;
			nxt_s.act_b = s_ff.buf_b;
		end else if (tick && kind == TWM_K_PC && s_ff.up && s_ff.cnt == top) begin
			nxt_s.act_a = s_ff.buf_a;
			nxt_s.act_b = s_ff.buf_b;
		end else if (tick && kind == TWM_K_PFC && !s_ff.up && s_ff.cnt == `TWM_BOTTOM) begin
			nxt_s.act_a = s_ff.buf_a;
			nxt_s.act_b = s_ff.buf_b;
		end
		if (rd_take) begin
			if (hit(avs_req.address, `TWM_OFS_CTRL_A)) begin
				nxt_s.rdata = {24'h000000, s_ff.ctrl_a};
			end else if (hit(avs_req.address, `TWM_OFS_CTRL_B)) begin
				nxt_s.rdata = {27'h0000000, s_ff.mode_hi, 2'h0, s_ff.run};
			end else if (hit(avs_req.address, `TWM_OFS_PRESC)) begin
				nxt_s.rdata = {24'h000000, s_ff.div};
			end else if (hit(avs_req.address, `TWM_OFS_COUNT)) begin
				nxt_s.rdata = {16'h0000, s_ff.cnt};
			end else if (hit(avs_req.address, `TWM_OFS_CMP_A)) begin
				nxt_s.rdata = {16'h0000, s_ff.buf_a};
			end else if (hit(avs_req.address, `TWM_OFS_CMP_B)) begin
				nxt_s.rdata = {16'h0000, s_ff.buf_b};
			end else if (hit(avs_req.address, `TWM_OFS_CAPT)) begin
				nxt_s.rdata = {16'h0000, s_ff.cap};
			end else if (hit(avs_req.address, `TWM_OFS_STAT)) begin
				nxt_s.rdata = {28'h0000000, pin_b.drive, pin_a.drive, s_ff.up, s_ff.ovf};
			end else begin
				nxt_s.rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// One assignment drives the whole struct so the port has a single driver.
	assign avs_rsp = '{readdata: s_ff.rdata,
		waitrequest: (avs_req.read || avs_req.write) && !s_ff.ack};

	twm_chan u_chan_a (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.match_en(match_en),
		.up(s_ff.up),
		.cnt(s_ff.cnt),
		.top(top),
		.cmp(s_ff.act_a),
		.kind(kind),
		.action(s_ff.ctrl_a[`TWM_A_ACT]),
		.tog_ok(tog_a),
		.pin(pin_a)
	);

	twm_chan u_chan_b (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.match_en(match_en),
		.up(s_ff.up),
		.cnt(s_ff.cnt),
		.top(top),
		.cmp(s_ff.act_b),
		.kind(kind),
		.action(s_ff.ctrl_a[`TWM_B_ACT]),
		.tog_ok(tog_b),
		.pin(pin_b)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_ctrl_a_wr;
		wr_acc && hit(avs_req.address, `TWM_OFS_CTRL_A) && avs_req.byteenable[0];
	endsequence
	sequence s_fast_top;
		tick && kind == TWM_K_FAST && s_ff.cnt == top && !cnt_wr;
	endsequence
	chk_mode_low_bits: assert property (
		s_ctrl_a_wr |=> mode[1:0] == $past(avs_req.writedata[1:0]))
		else $error("mode low bits not taken");
	chk_ovf_at_max: assert property (
		(tick && kind == TWM_K_NORMAL && s_ff.cnt == `TWM_MAX) |=> s_ff.ovf)
		else $error("overflow missed at max");
	chk_ctc_wrap: assert property (
		(tick && kind == TWM_K_CTC && s_ff.cnt == top && !cnt_wr) |=> s_ff.cnt == `TWM_BOTTOM)
		else $error("clear on match failed");
	chk_cmp_immediate: assert property (
		(wr_acc && imm && hit(avs_req.address, `TWM_OFS_CMP_A) && avs_req.byteenable[1:0] == 2'h3)
		|=> s_ff.act_a == $past(avs_req.writedata[15:0]))
		else $error("compare not loaded at once");
	chk_fast_top: assert property (
		s_fast_top |=> s_ff.ovf && s_ff.cnt == `TWM_BOTTOM && s_ff.act_a == $past(s_ff.buf_a))
		else $error("fast top handling wrong");
	chk_ovf_bottom: assert property (
		(tick && dual && !s_ff.up && s_ff.cnt == `TWM_BOTTOM) |=> s_ff.ovf)
		else $error("overflow missed at bottom");
	chk_dual_turn: assert property (
		(tick && dual && s_ff.up && s_ff.cnt == top && top != `TWM_BOTTOM && !cnt_wr)
		|=> !s_ff.up && s_ff.cnt == $past(top) - 16'h0001)
		else $error("top not held one tick");
	chk_dual_bottom: assert property (
		(tick && dual && !s_ff.up && s_ff.cnt == `TWM_BOTTOM && top != `TWM_BOTTOM && !cnt_wr)
		|=> s_ff.up && s_ff.cnt == 16'h0001)
		else $error("bottom turn wrong");
	chk_set_wins: assert property (
		(ovf_set && wr_acc && hit(avs_req.address, `TWM_OFS_STAT)) |=> s_ff.ovf)
		else $error("overflow lost to clear");
endmodule // twm_top

// [tb/test_timer16_waveform_mode_control.sv]
`timescale 1ns/1ps
`include "twm_map.svh"
module test_timer16_waveform_mode_control;
	import twm_pkg::*;
	logic clk;
	logic rst_n;
	twm_avs_req_t avs_req;
	twm_avs_rsp_t avs_rsp;
	twm_pin_t pin_a;
	twm_pin_t pin_b;
	logic dir_out;
	logic port_val;
	logic pad_a;
	logic pad_b;
	int miscompares;
	int tests_run;
	logic [31:0] stat_rd;
	// Each row is mode, action for both channels, then expected override enables of A and B.
	localparam logic [7:0] rows [16] = '{8'h00, 8'h07, 8'h4b, 8'hcf, 8'h54, 8'he6, 8'hf6,
		8'h14, 8'h96, 8'hb6, 8'h84, 8'hd8, 8'h7f, 8'hab, 8'hd4, 8'h60};

	twm_top dut (.clk(clk), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp),
		.pin_a(pin_a), .pin_b(pin_b));
	twm_pin_model port_a (.dir_out(dir_out), .port_val(port_val), .pin(pin_a), .pad(pad_a));
	twm_pin_model port_b (.dir_out(dir_out), .port_val(port_val), .pin(pin_b), .pad(pad_b));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pins(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: pin enables %b, expected %b", $time, got, exp);
		end
	endtask

	// The request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clk);
		avs_req.read <= !wr;
		avs_req.write <= wr;
		avs_req.address <= addr;
		avs_req.writedata <= wd;
		avs_req.byteenable <= 4'hf;
		// Only the watchdog ends a wait that never gets its answer.
		do begin
			@(posedge clk);
		end while (avs_rsp.waitrequest !== 1'b0);
		rd = avs_rsp.readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk_word(x, e);
	endtask

	// Stops the timer first so that the new mode starts from a known count.
	task automatic setup(input logic [3:0] mode, input logic [1:0] aa, input logic [1:0] ab,
			input logic [15:0] ca, input logic [15:0] cb);
		wr(`TWM_OFS_CTRL_B, 32'h0);
		wr(`TWM_OFS_COUNT, 32'h0);
		wr(`TWM_OFS_STAT, 32'h1);
		wr(`TWM_OFS_CAPT, 32'h7);
		wr(`TWM_OFS_CMP_A, {16'h0, ca});
		wr(`TWM_OFS_CMP_B, {16'h0, cb});
		wr(`TWM_OFS_CTRL_A, {24'h0, aa, ab, 2'h0, mode[1:0]});
		wr(`TWM_OFS_CTRL_B, {27'h0, mode[3:2], 3'h0});
	endtask

	// High time is counted over a whole number of periods, so it does not depend on the phase.
	task automatic duty(input logic [3:0] mode, input logic [1:0] aa, input logic [1:0] ab,
			input logic [15:0] ca, input logic [15:0] cb, input int period,
			input logic [15:0] exp_a, input logic [15:0] exp_b, input logic exp_ovf);
		logic [15:0] hi_a;
		logic [15:0] hi_b;
		logic [31:0] st;
		hi_a = 16'h0;
		hi_b = 16'h0;
		setup(mode, aa, ab, ca, cb);
		wr(`TWM_OFS_CTRL_B, {27'h0, mode[3:2], 3'h1});
		repeat (2 * period) @(posedge clk);
		repeat (period) begin
			@(posedge clk);
			hi_a += 16'(pad_a);
			hi_b += 16'(pad_b);
		end
		chk_word({16'h0, hi_a}, {16'h0, exp_a});
		chk_word({16'h0, hi_b}, {16'h0, exp_b});
		bus(1'b0, `TWM_OFS_STAT, 32'h0, st);
		chk_word({31'h0, st[`TWM_ST_OVF]}, {31'h0, exp_ovf});
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("Error at %0t: watchdog expired", $time);
		give_verdict();
	end

	initial begin
		rst_n = 1'b0;
		avs_req = '0;
		dir_out = 1'b1;
		port_val = 1'b0;
		miscompares = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			setup(rows[i][7:4], rows[i][3:2], rows[i][3:2], 16'h0, 16'h0);
			@(posedge clk);
			chk_pins({pin_a.enable, pin_b.enable}, rows[i][1:0]);
		end
		wr(`TWM_OFS_CTRL_A, 32'hd3);
		rd_chk(`TWM_OFS_CTRL_A, 32'hd3);
		duty(4'h4, 2'h1, 2'h1, 16'h3, 16'h1, 40, 16'd20, 16'd20, 1'b0);
		duty(4'h4, 2'h2, 2'h3, 16'h3, 16'h1, 40, 16'd0, 16'd40, 1'b0);
		duty(4'hc, 2'h1, 2'h3, 16'h2, 16'h5, 48, 16'd24, 16'd48, 1'b0);
		duty(4'h5, 2'h2, 2'h3, 16'h40, 16'h40, 256, 16'd65, 16'd191, 1'b1);
		duty(4'h5, 2'h2, 2'h3, 16'hff, 16'hff, 256, 16'd256, 16'd0, 1'b1);
		duty(4'he, 2'h2, 2'h3, 16'h2, 16'h2, 48, 16'd18, 16'd30, 1'b1);
		duty(4'hf, 2'h1, 2'h1, 16'h3, 16'h1, 40, 16'd20, 16'd0, 1'b1);
		duty(4'h1, 2'h2, 2'h3, 16'h40, 16'h40, 510, 16'd128, 16'd382, 1'b1);
		duty(4'h1, 2'h2, 2'h2, 16'h0, 16'hff, 510, 16'd0, 16'd510, 1'b1);
		duty(4'ha, 2'h2, 2'h3, 16'h2, 16'h2, 56, 16'd16, 16'd40, 1'b1);
		duty(4'h8, 2'h2, 2'h3, 16'h2, 16'h2, 56, 16'd16, 16'd40, 1'b1);
		// The clear write lands in the very cycle that the count passes MAX: the set must win.
		setup(4'h0, 2'h0, 2'h0, 16'h0, 16'h0);
		wr(`TWM_OFS_CTRL_B, 32'h1);
		wr(`TWM_OFS_COUNT, 32'hfffd);
		wr(`TWM_OFS_STAT, 32'h1);
		bus(1'b0, `TWM_OFS_STAT, 32'h0, stat_rd);
		chk_word({31'h0, stat_rd[`TWM_ST_OVF]}, 32'h1);
		wr(`TWM_OFS_STAT, 32'h1);
		bus(1'b0, `TWM_OFS_STAT, 32'h0, stat_rd);
		chk_word({31'h0, stat_rd[`TWM_ST_OVF]}, 32'h0);
		// A divided tick halves the match rate, so the toggle period doubles.
		wr(`TWM_OFS_PRESC, 32'h1);
		rd_chk(`TWM_OFS_PRESC, 32'h1);
		duty(4'h4, 2'h1, 2'h1, 16'h3, 16'h1, 80, 16'd40, 16'd40, 1'b0);
		// A second reset in mid-run must drop both overrides and clear the registers.
		wr(`TWM_OFS_CTRL_A, 32'hf0);
		@(posedge clk);
		chk_pins({pin_a.enable, pin_b.enable}, 2'b11);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_pins({pin_a.enable, pin_b.enable}, 2'b00);
		// Mode 0 is single-slope, so the status word reports counting up after reset.
		for (int i = 0; i < 8; i++) begin
			rd_chk(5'(i * 4), (i == 7) ? 32'h2 : 32'h0);
		end
		give_verdict();
	end
endmodule // test_timer16_waveform_mode_control

// [tb/twm_pin_model.sv]
`timescale 1ns/1ps
module twm_pin_model (
	// Port side.
	input wire logic dir_out,
	input wire logic port_val,
	// Override from the timer.
	input twm_pkg::twm_pin_t pin,
	// Pad level.
	output logic pad
);
	import twm_pkg::*;
	// The pad has a pull-up, so an undriven pad reads high and never keeps a stale level.
	always_comb begin
		if (!dir_out) begin
			pad = 1'b1;
		end else if (pin.enable) begin
			pad = pin.drive;
		end else begin
			pad = port_val;
		end
	end
endmodule // twm_pin_model
